// ===== src/bss_pkg.sv
// package: constants and carrier types for the burner sequence supervisor
package bss_pkg;

  // clock and seconds tick
  localparam int CLK_PERIOD_NS = 10;
  localparam int SECOND_NS = 1_000_000_000;
  localparam int TICK_CYCLES = SECOND_NS / CLK_PERIOD_NS;

  // sequence times in seconds
  localparam int TW = 16;
  localparam logic [15:0] INITIATE_S = 16'h000a;
  localparam logic [15:0] HOLD_REPORT_S = 16'h0005;
  localparam logic [15:0] HOLD_LOCK_S = 16'h00f0;
  localparam logic [15:0] STANDBY_FLAME_S = 16'h00f0;
  localparam logic [15:0] INTERLOCK_OPEN_S = 16'h001e;
  localparam logic [15:0] TRIAL_LONG_S = 16'h000a;
  localparam logic [15:0] TRIAL_SHORT_S = 16'h0004;
  localparam logic [15:0] MAIN_EST_S = 16'h000a;
  localparam logic [15:0] POSTRUN_CLOSE_S = 16'h0005;
  localparam logic [15:0] FB_SETTLE_S = 16'h0001;

  // operating-time limit for jumper changes, 200 hours in seconds
  localparam int HW = 20;
  localparam int JUMPER_LOCK_HOURS = 200;
  localparam int SECONDS_PER_HOUR = 3600;
  localparam int JUMPER_LOCK_S = JUMPER_LOCK_HOURS * SECONDS_PER_HOUR;

  // fault codes
  localparam logic [7:0] FAULT_NONE = 8'h00;
  localparam logic [7:0] FAULT_LINE_HOLD = 8'h01;
  localparam logic [7:0] FAULT_STANDBY_FLAME = 8'h02;
  localparam logic [7:0] FAULT_OUTPUT_FB = 8'h03;
  localparam logic [7:0] FAULT_INTERNAL = 8'h04;
  localparam logic [7:0] FAULT_INTERLOCK = 8'h05;
  localparam logic [7:0] FAULT_NO_FLAME = 8'h06;
  localparam logic [7:0] FAULT_FLAME_LOSS = 8'h07;
  localparam logic [7:0] FAULT_AMP_MISMATCH = 8'h2e;
  localparam logic [7:0] FAULT_JUMPER_CHANGE = 8'h6e;

  typedef enum logic [2:0] {
    BSS_VP_NEVER = 3'h0,
    BSS_VP_BEFORE = 3'h1,
    BSS_VP_AFTER = 3'h2,
    BSS_VP_BOTH = 3'h3,
    BSS_VP_SPLIT = 3'h4
  } bss_vp_sched_type;

  // field inputs from burner hardware
  typedef struct packed {
    logic call_for_heat;
    logic demand_second;
    logic limits_ok;
    logic interlock_closed;
    logic flame;
    logic slow_amplifier;
    logic line_ok;
    logic internal_fault;
  } bss_field_type;

  // output terminal feedback and the outputs themselves
  typedef struct packed {
    logic ignition;
    logic pilot;
    logic main1;
    logic main2;
  } bss_valves_type;

  // site jumpers, 1 = intact
  typedef struct packed {
    logic pilot_trial_length_jumper;
    logic flame_failure_action_jumper;
    logic pilot_style_jumper;
  } bss_jumpers_type;

  typedef struct packed {
    logic power;
    logic pilot;
    logic flame;
    logic main;
    logic alarm;
  } bss_leds_type;

endpackage

// ===== src/bss_tick.sv
// seconds tick divider with restart
`timescale 1ns/1ns
`default_nettype none

module bss_tick #(
  parameter int DIV = 100_000_000
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic restart_i,
  output logic tick_o
);

  logic [31:0] count;
  logic [31:0] next_count;
  logic next_tick;

  always_comb begin
    next_count = count + 32'h0000_0001;
    next_tick = 1'b0;
    if (restart_i) begin
      next_count = 32'h0000_0000;
    end else if (count == 32'(DIV - 1)) begin
      next_count = 32'h0000_0000;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      count <= 32'h0000_0000;
      tick_o <= 1'b0;
    end else begin
      count <= next_count;
      tick_o <= next_tick;
    end
  end

endmodule

`default_nettype wire

// ===== src/bss_supervisor.sv
// burner sequence supervisor: sequencer, flame and output supervision, lockout
// Summary of operation
// - power-up initiate lasts ten seconds
// - line fault holds, reported five seconds minimum
// - line restored restarts initiate; four-minute hold locks
// - jumper change after 200 hours: hard lockout 110
// - standby flame beyond 240 seconds locks out
// - standby/check: energized output or fault locks
// - slow amplifier with relight jumper: fault 46
// - interlock open 30 s standby, any in check
// - leave standby on heat, demand, limits ok, interlock closed
// - check: flame present stays in standby
// - scheduled valve proving before ignition trial
// - pilot trial 10 or 4 s, flame required
// - trial: pilot off, main on, fault lock
// - intermittent: flame proven drops ignition, opens mains
// - interrupted: trial end mains, pilot off 10 s later
// - pilot style jumper picks intermittent or interrupted
// - run flame loss: lockout or relight by jumper
// - run until controller input opens
// - run: ignition on, main off, fault lock
// - run: pilot state must match pilot style
// - interlock closes within 5 s; ignored during proving
// - five indicators: power steady on, flame follows input, rest follow the state
`timescale 1ns/1ns
`default_nettype none

module bss_supervisor #(
  parameter int TICK_DIV = bss_pkg::TICK_CYCLES,
  parameter int JUMPER_LOCK_SECS = bss_pkg::JUMPER_LOCK_S
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire bss_pkg::bss_field_type field_i,
  input wire bss_pkg::bss_valves_type feedback_i,
  input wire bss_pkg::bss_jumpers_type jumpers_i,
  input wire bss_pkg::bss_vp_sched_type vp_sched_i,
  input wire logic [15:0] vp_test_secs_i,
  input wire logic lockout_reset_i,
  output bss_pkg::bss_valves_type outputs_o,
  output bss_pkg::bss_leds_type leds_o,
  output logic hold_report_o,
  output logic lockout_o,
  output logic hard_lockout_o,
  output logic [7:0] fault_code_o
);
  import bss_pkg::*;

  typedef enum logic [10:0] {
    ST_INITIATE = 11'h001,
    ST_HOLD = 11'h002,
    ST_STANDBY = 11'h004,
    ST_SAFE_CHECK = 11'h008,
    ST_VP_BEFORE = 11'h010,
    ST_TRIAL = 11'h020,
    ST_MAIN_EST = 11'h040,
    ST_RUN = 11'h080,
    ST_VP_AFTER = 11'h100,
    ST_POSTRUN = 11'h200,
    ST_LOCKOUT = 11'h400
  } bss_state_type;

  bss_state_type state;
  bss_state_type next_state;
  logic [15:0] secs;
  logic [15:0] next_secs;
  logic [15:0] flame_secs;
  logic [15:0] next_flame_secs;
  logic [15:0] open_secs;
  logic [15:0] next_open_secs;
  logic [HW-1:0] hours_secs;
  logic [HW-1:0] next_hours_secs;
  bss_jumpers_type jumper_ref;
  bss_jumpers_type next_jumper_ref;
  logic jumper_seen;
  logic next_jumper_seen;
  logic hard;
  logic next_hard;
  logic [7:0] fault;
  logic [7:0] next_fault;
  bss_valves_type outs;
  bss_valves_type next_outs;
  bss_leds_type leds;
  bss_leds_type next_leds;
  logic tick;
  logic entering;
  logic aged;
  logic settled;
  logic mains_fb;
  logic [15:0] trial_secs;

  // one tick source; restarting it on entry aligns every state timer
  bss_tick #(
    .DIV(TICK_DIV)
  ) u_tick (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .restart_i(entering),
    .tick_o(tick)
  );

  function automatic logic [15:0] bump(input logic [15:0] v, input logic en);
    bump = (en && v != 16'hffff) ? v + 16'h0001 : v;
  endfunction

  function automatic logic vp_sched_first(input bss_vp_sched_type s);
    vp_sched_first = (s == BSS_VP_BEFORE) || (s == BSS_VP_BOTH) || (s == BSS_VP_SPLIT);
  endfunction

  function automatic logic vp_sched_last(input bss_vp_sched_type s);
    vp_sched_last = (s == BSS_VP_AFTER) || (s == BSS_VP_BOTH) || (s == BSS_VP_SPLIT);
  endfunction

  assign entering = (next_state != state);
  assign aged = (hours_secs >= HW'(JUMPER_LOCK_SECS));
  assign settled = (secs >= FB_SETTLE_S);
  assign mains_fb = feedback_i.main1 | feedback_i.main2;
  assign trial_secs = jumpers_i.pilot_trial_length_jumper ? TRIAL_LONG_S : TRIAL_SHORT_S;

  always_comb begin
    next_state = state;
    next_fault = fault;
    next_hard = hard;
    next_jumper_ref = jumper_ref;
    next_jumper_seen = 1'b1;
    next_hours_secs = hours_secs;
    next_flame_secs = 16'h0000;
    next_open_secs = 16'h0000;
    if (tick && !aged) begin
      next_hours_secs = hours_secs + HW'(1);
    end
    if (!jumper_seen || (!aged && state != ST_LOCKOUT)) begin
      next_jumper_ref = jumpers_i;
    end
    unique case (state)
      ST_INITIATE: begin
        if (!field_i.line_ok) begin
          next_state = ST_HOLD;
        end else if (secs >= INITIATE_S) begin
          next_state = ST_STANDBY;
        end
      end
      ST_HOLD: begin
        if (secs >= HOLD_LOCK_S) begin
          next_state = ST_LOCKOUT;
          next_fault = FAULT_LINE_HOLD;
        end else if (field_i.line_ok && secs >= HOLD_REPORT_S) begin
          next_state = ST_INITIATE;
        end
      end
      ST_STANDBY: begin
        next_flame_secs = field_i.flame ? bump(flame_secs, tick) : 16'h0000;
        next_open_secs = field_i.interlock_closed ? 16'h0000 : bump(open_secs, tick);
        if (feedback_i != '0) begin
          next_state = ST_LOCKOUT;
          next_fault = FAULT_OUTPUT_FB;
        end else if (field_i.internal_fault) begin
          next_state = ST_LOCKOUT;
          next_fault = FAULT_INTERNAL;
        end else if (field_i.slow_amplifier && jumpers_i.flame_failure_action_jumper) begin
          next_state = ST_LOCKOUT;
          next_fault = FAULT_AMP_MISMATCH;
        end else if (flame_secs > STANDBY_FLAME_S) begin
          next_state = ST_LOCKOUT;
          next_fault = FAULT_STANDBY_FLAME;
        end else if (open_secs > INTERLOCK_OPEN_S) begin
          next_state = ST_LOCKOUT;
          next_fault = FAULT_INTERLOCK;
        end else if (field_i.call_for_heat && field_i.demand_second && field_i.limits_ok
                     && field_i.interlock_closed) begin
          next_state = ST_SAFE_CHECK;
        end
      end
      ST_SAFE_CHECK: begin
        if (feedback_i != '0) begin
          next_state = ST_LOCKOUT;
          next_fault = FAULT_OUTPUT_FB;
        end else if (field_i.internal_fault) begin
          next_state = ST_LOCKOUT;
          next_fault = FAULT_INTERNAL;
        end else if (!field_i.interlock_closed) begin
          next_state = ST_LOCKOUT;
          next_fault = FAULT_INTERLOCK;
        end else if (field_i.flame) begin
          next_state = ST_STANDBY;
        end else if (vp_sched_first(vp_sched_i)) begin
          next_state = ST_VP_BEFORE;
        end else begin
          next_state = ST_TRIAL;
        end
      end
      ST_VP_BEFORE: begin
        // proving internals are external; this only holds the slot open
        if (field_i.internal_fault) begin
          next_state = ST_LOCKOUT;
          next_fault = FAULT_INTERNAL;
        end else if (secs >= vp_test_secs_i) begin
          next_state = ST_TRIAL;
        end
      end
      ST_TRIAL: begin
        if (field_i.internal_fault) begin
          next_state = ST_LOCKOUT;
          next_fault = FAULT_INTERNAL;
        end else if (mains_fb || (settled && !(feedback_i.ignition && feedback_i.pilot))) begin
          next_state = ST_LOCKOUT;
          next_fault = FAULT_OUTPUT_FB;
        end else if (jumpers_i.pilot_style_jumper && field_i.flame) begin
          next_state = ST_RUN;
        end else if (secs >= trial_secs) begin
          if (!field_i.flame) begin
            next_state = ST_LOCKOUT;
            next_fault = FAULT_NO_FLAME;
          end else begin
            next_state = ST_MAIN_EST;
          end
        end
      end
      ST_MAIN_EST: begin
        if (field_i.internal_fault) begin
          next_state = ST_LOCKOUT;
          next_fault = FAULT_INTERNAL;
        end else if (!field_i.flame) begin
          next_state = ST_LOCKOUT;
          next_fault = FAULT_FLAME_LOSS;
        end else if (secs >= MAIN_EST_S) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (field_i.internal_fault) begin
          next_state = ST_LOCKOUT;
          next_fault = FAULT_INTERNAL;
        end else if (settled && (feedback_i.ignition || !feedback_i.main1
                                 || !feedback_i.main2)) begin
          next_state = ST_LOCKOUT;
          next_fault = FAULT_OUTPUT_FB;
        end else if (settled && (feedback_i.pilot != jumpers_i.pilot_style_jumper)) begin
          next_state = ST_LOCKOUT;
          next_fault = FAULT_OUTPUT_FB;
        end else if (!field_i.flame) begin
          if (jumpers_i.flame_failure_action_jumper) begin
            next_state = ST_STANDBY;
          end else begin
            next_state = ST_LOCKOUT;
            next_fault = FAULT_FLAME_LOSS;
          end
        end else if (!field_i.call_for_heat) begin
          next_state = vp_sched_last(vp_sched_i) ? ST_VP_AFTER : ST_POSTRUN;
        end
      end
      ST_VP_AFTER: begin
        if (field_i.internal_fault) begin
          next_state = ST_LOCKOUT;
          next_fault = FAULT_INTERNAL;
        end else if (secs >= vp_test_secs_i) begin
          next_state = ST_POSTRUN;
        end
      end
      ST_POSTRUN: begin
        if (field_i.interlock_closed) begin
          next_state = ST_STANDBY;
        end else if (secs >= POSTRUN_CLOSE_S) begin
          next_state = ST_LOCKOUT;
          next_fault = FAULT_INTERLOCK;
        end
      end
      ST_LOCKOUT: begin
        // latched until reset; a hard lockout ignores it
        if (lockout_reset_i && !hard) begin
          next_state = ST_INITIATE;
          next_fault = FAULT_NONE;
        end
      end
      default: begin
        next_state = ST_LOCKOUT;
        next_fault = FAULT_INTERNAL;
      end
    endcase
    // line check in every state except hold and lockout
    if (!field_i.line_ok && state != ST_HOLD && state != ST_LOCKOUT) begin
      next_state = ST_HOLD;
    end
    if (jumper_seen && aged && jumpers_i != jumper_ref) begin
      next_state = ST_LOCKOUT;
      next_fault = FAULT_JUMPER_CHANGE;
      next_hard = 1'b1;
    end
    next_secs = (next_state != state) ? 16'h0000 : bump(secs, tick);
  end

  always_comb begin
    next_outs = '0;
    if (next_state == ST_TRIAL) begin
      next_outs.ignition = 1'b1;
      next_outs.pilot = 1'b1;
    end
    // mains with pilot for main establishing
    if (next_state == ST_MAIN_EST) begin
      next_outs.pilot = 1'b1;
      next_outs.main1 = 1'b1;
      next_outs.main2 = 1'b1;
    end
    // pilot kept in run only when intermittent
    if (next_state == ST_RUN) begin
      next_outs.pilot = jumpers_i.pilot_style_jumper;
      next_outs.main1 = 1'b1;
      next_outs.main2 = 1'b1;
    end
    next_leds.power = 1'b1;
    next_leds.pilot = next_outs.pilot;
    next_leds.flame = field_i.flame;
    next_leds.main = next_outs.main1 | next_outs.main2;
    next_leds.alarm = (next_state == ST_LOCKOUT);
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state <= ST_INITIATE;
      secs <= 16'h0000;
      flame_secs <= 16'h0000;
      open_secs <= 16'h0000;
      hours_secs <= '0;
      jumper_ref <= '0;
      jumper_seen <= 1'b0;
      hard <= 1'b0;
      fault <= FAULT_NONE;
      outs <= '0;
      leds <= '0;
    end else begin
      state <= next_state;
      secs <= next_secs;
      flame_secs <= next_flame_secs;
      open_secs <= next_open_secs;
      hours_secs <= next_hours_secs;
      jumper_ref <= next_jumper_ref;
      jumper_seen <= next_jumper_seen;
      hard <= next_hard;
      fault <= next_fault;
      // outputs follow the state, all off in lockout
      outs <= next_outs;
      leds <= next_leds;
    end
  end

  assign outputs_o = outs;
  assign leds_o = leds;
  assign hold_report_o = (state == ST_HOLD);
  assign lockout_o = (state == ST_LOCKOUT);
  assign hard_lockout_o = hard;
  assign fault_code_o = fault;

endmodule

`default_nettype wire

// ===== verification/bss_supervisor_sva.sv
// checker: timing and lockout assertions on the supervisor ports
`timescale 1ns/1ns
`default_nettype none
module bss_supervisor_sva
  import bss_pkg::*;
#(
  parameter int TICK_DIV = 10
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire bss_pkg::bss_jumpers_type jumpers_i,
  input wire logic lockout_reset_i,
  input wire bss_pkg::bss_valves_type outputs_o,
  input wire bss_pkg::bss_leds_type leds_o,
  input wire logic hold_report_o,
  input wire logic lockout_o,
  input wire logic hard_lockout_o,
  input wire logic [7:0] fault_code_o
);
  localparam int HOLD_MIN = 5 * TICK_DIV - 1;
  localparam int HOLD_MAX = 240 * TICK_DIV + 2;
  localparam int INIT_MIN = 10 * TICK_DIV - 2;
  int hold_cnt;
  int ign_cnt;
  int up_cnt;
  // counters restart with reset so a second reset starts clean
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hold_cnt <= 0;
      ign_cnt <= 0;
      up_cnt <= 0;
    end else begin
      hold_cnt <= hold_report_o ? hold_cnt + 1 : 0;
      ign_cnt <= outputs_o.ignition ? ign_cnt + 1 : 0;
      up_cnt <= (up_cnt < INIT_MIN) ? up_cnt + 1 : up_cnt;
    end
  end
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  sequence lock_held;
    lockout_o && !lockout_reset_i;
  endsequence
  sequence lock_freed;
    lockout_o && lockout_reset_i && !hard_lockout_o;
  endsequence
  sequence hold_ends;
    $fell(hold_report_o);
  endsequence
  AST_LOCK_DROPS: assert property (lockout_o |-> outputs_o == '0)
    else $error("drives on in lockout");
  AST_LOCK_LATCH: assert property (lock_held |=> lockout_o)
    else $error("lockout left without reset");
  AST_LOCK_CLEAR: assert property (lock_freed |-> ##[1:2] !lockout_o)
    else $error("lockout reset ignored");
  AST_ALARM_LED: assert property (lockout_o |-> leds_o.alarm)
    else $error("alarm led off in lockout");
  AST_POWER_LED: assert property (!$past(rst_i) |-> leds_o.power)
    else $error("power led off");
  AST_HARD_STICKY: assert property (hard_lockout_o |=> hard_lockout_o && lockout_o)
    else $error("hard lockout not sticky");
  AST_HARD_CODE: assert property ($rose(hard_lockout_o) |-> ##[0:1] fault_code_o == FAULT_JUMPER_CHANGE)
    else $error("hard lockout code wrong");
  AST_IGN_NO_MAIN: assert property (outputs_o.ignition |-> !outputs_o.main1 && !outputs_o.main2)
    else $error("ignition with main valve");
  AST_HOLD_MIN: assert property (hold_ends |-> hold_cnt >= HOLD_MIN)
    else $error("hold shorter than five seconds");
  AST_HOLD_LOCK: assert property (hold_cnt <= HOLD_MAX)
    else $error("hold beyond four minutes");
  AST_INIT_QUIET: assert property (outputs_o != '0 |-> up_cnt >= INIT_MIN)
    else $error("drives during initiate");
  AST_TRIAL_LEN: assert property
    (ign_cnt <= (jumpers_i.pilot_trial_length_jumper ? 10 : 4) * TICK_DIV + 2)
    else $error("ignition beyond trial");
endmodule
bind bss_supervisor bss_supervisor_sva #(.TICK_DIV(TICK_DIV)) u_sva (
  .core_clk_i(core_clk_i),
  .rst_i(rst_i),
  .jumpers_i(jumpers_i),
  .lockout_reset_i(lockout_reset_i),
  .outputs_o(outputs_o),
  .leds_o(leds_o),
  .hold_report_o(hold_report_o),
  .lockout_o(lockout_o),
  .hard_lockout_o(hard_lockout_o),
  .fault_code_o(fault_code_o)
);
`default_nettype wire

// ===== verification/bss_field_model.sv
// field model: terminal feedback, flame and interlock of the burner
`timescale 1ns/1ns
`default_nettype none
module bss_field_model (
  input wire logic core_clk_i,
  input wire bss_pkg::bss_valves_type drive_i,
  input wire logic flame_en_i,
  input wire logic fb_stuck_i,
  output bss_pkg::bss_valves_type feedback_o,
  output logic flame_o,
  output logic interlock_closed_o
);
  import bss_pkg::*;
  logic [1:0] lit;
  // stuck main1 models a welded contact
  assign feedback_o = drive_i | {2'h0, fb_stuck_i, 1'b0};
  // flame follows gas two cycles late
  always_ff @(posedge core_clk_i) begin
    lit <= {lit[0], flame_en_i & (drive_i.pilot | drive_i.main1)};
  end
  assign flame_o = lit[1];
  assign interlock_closed_o = !(drive_i.main1 | drive_i.main2);
endmodule
`default_nettype wire

// ===== verification/burner_sequence_supervisor_tb_top.sv
// testbench: sequence, lockout and hold scenarios for the supervisor
`timescale 1ns/1ns
`default_nettype none
module burner_sequence_supervisor_tb_top;
  import bss_pkg::*;
  logic core_clk_i;
  logic rst_i;
  logic lrst;
  logic flame_en;
  logic fb_stuck;
  logic m_flame;
  logic m_ilk;
  bss_field_type fld;
  bss_field_type fw;
  bss_jumpers_type jmp;
  bss_valves_type fb;
  bss_vp_sched_type interspace_pressure_switch;
  bss_valves_type outputs_o;
  bss_leds_type leds_o;
  logic hold_report_o;
  logic lockout_o;
  logic hard_lockout_o;
  logic [7:0] fault_code_o;
  int fails;
  int check_count;
  int n;
  always_comb begin
    fw = fld;
    // a forced flame bit stands for a flame-simulating signal with no gas
    fw.flame = m_flame | fld.flame;
    fw.interlock_closed = fld.interlock_closed & m_ilk;
  end
  bss_supervisor #(.TICK_DIV(10), .JUMPER_LOCK_SECS(300)) u_bss_supervisor (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .field_i(fw),
    .feedback_i(fb),
    .jumpers_i(jmp),
    .vp_sched_i(interspace_pressure_switch),
    .vp_test_secs_i(16'h000a),
    .lockout_reset_i(lrst),
    .outputs_o(outputs_o),
    .leds_o(leds_o),
    .hold_report_o(hold_report_o),
    .lockout_o(lockout_o),
    .hard_lockout_o(hard_lockout_o),
    .fault_code_o(fault_code_o)
  );
  bss_field_model u_bss_field_model (
    .core_clk_i(core_clk_i),
    .drive_i(outputs_o),
    .flame_en_i(flame_en),
    .fb_stuck_i(fb_stuck),
    .feedback_o(fb),
    .flame_o(m_flame),
    .interlock_closed_o(m_ilk)
  );
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic complete_run();
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // sampling on the falling edge keeps clear of the launch edge
  task automatic tick(input int k);
    repeat (k) @(negedge core_clk_i);
  endtask
  task automatic wait_out(input logic [3:0] e, input int mx, output int c);
    c = 0;
    while (outputs_o !== e && c < mx) begin
      tick(1);
      c++;
    end
    chk("drives", {4'h0, e}, {4'h0, outputs_o});
  endtask
  task automatic wait_lock(input int mx, input logic [7:0] code, output int c);
    c = 0;
    while (lockout_o !== 1'b1 && c < mx) begin
      tick(1);
      c++;
    end
    chk("lockout", 8'h01, {7'h0, lockout_o});
    chk("fault_code", code, fault_code_o);
  endtask
  task automatic clear_lock();
    @(posedge core_clk_i);
    lrst <= 1'b1;
    @(posedge core_clk_i);
    lrst <= 1'b0;
    tick(3);
    chk("lock_cleared", 8'h00, {7'h0, lockout_o});
    tick(110);
  endtask
  initial begin
    fails = 0;
    check_count = 0;
    rst_i = 1'b1;
    lrst = 1'b0;
    flame_en = 1'b1;
    fb_stuck = 1'b0;
    interspace_pressure_switch = BSS_VP_NEVER;
    fld = 8'h72;
    jmp = 3'h7;
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    // call for heat from the start
    @(posedge core_clk_i);
    fld.call_for_heat <= 1'b1;
    wait_out(4'hc, 200, n);
    chk("initiate_len", 8'h01, {7'h0, n >= 95});
    chk("pilot_led", 8'h01, {7'h0, leds_o.pilot});
    wait_out(4'h7, 20, n);
    chk("main_led", 8'h01, {7'h0, leds_o.main});
    tick(30);
    chk("run_stays", 8'h07, {4'h0, outputs_o});
    @(posedge core_clk_i);
    fld.call_for_heat <= 1'b0;
    wait_out(4'h0, 20, n);
    tick(80);
    // interrupted pilot with the short trial
    @(posedge core_clk_i);
    jmp <= 3'h2;
    fld.call_for_heat <= 1'b1;
    wait_out(4'hc, 40, n);
    wait_out(4'h7, 60, n);
    chk("short_trial", 8'h01, {7'h0, n >= 38 && n <= 42});
    wait_out(4'h3, 120, n);
    chk("pilot_hold", 8'h01, {7'h0, n >= 98 && n <= 102});
    // flame loss with relight: standby, a proving slot, then a trial with no flame
    flame_en <= 1'b0;
    interspace_pressure_switch <= BSS_VP_BEFORE;
    wait_out(4'h0, 20, n);
    chk("relight", 8'h00, {7'h0, lockout_o});
    wait_out(4'hc, 200, n);
    chk("vp_slot", 8'h01, {7'h0, n >= 95});
    wait_lock(60, 8'h06, n);
    chk("lock_time", 8'h01, {7'h0, n >= 38 && n <= 42});
    chk("lock_drives", 8'h00, {4'h0, outputs_o});
    chk("alarm_led", 8'h01, {7'h0, leds_o.alarm});
    @(posedge core_clk_i);
    fld.call_for_heat <= 1'b0;
    flame_en <= 1'b1;
    tick(20);
    chk("latched", 8'h01, {7'h0, lockout_o});
    clear_lock();
    // standby faults, one at a time
    @(posedge core_clk_i);
    fb_stuck <= 1'b1;
    wait_lock(5, 8'h03, n);
    fb_stuck <= 1'b0;
    clear_lock();
    @(posedge core_clk_i);
    fld.slow_amplifier <= 1'b1;
    wait_lock(5, 8'h2e, n);
    fld.slow_amplifier <= 1'b0;
    clear_lock();
    @(posedge core_clk_i);
    fld.interlock_closed <= 1'b0;
    wait_lock(330, 8'h05, n);
    chk("ilk_time", 8'h01, {7'h0, n >= 300});
    fld.interlock_closed <= 1'b1;
    clear_lock();
    @(posedge core_clk_i);
    fld.internal_fault <= 1'b1;
    wait_lock(5, 8'h04, n);
    fld.internal_fault <= 1'b0;
    clear_lock();
    // flame without gas: safe check falls back, standby flame locks
    @(posedge core_clk_i);
    fld.flame <= 1'b1;
    fld.call_for_heat <= 1'b1;
    tick(30);
    chk("flame_no_trial", 8'h00, {3'h0, lockout_o, outputs_o});
    @(posedge core_clk_i);
    fld.call_for_heat <= 1'b0;
    wait_lock(2500, 8'h02, n);
    chk("flame_time", 8'h01, {7'h0, n >= 2400});
    fld.flame <= 1'b0;
    clear_lock();
    // line loss: short dip, then a lasting one
    @(posedge core_clk_i);
    fld.line_ok <= 1'b0;
    tick(3);
    chk("hold", 8'h01, {7'h0, hold_report_o});
    fld.line_ok <= 1'b1;
    n = 0;
    while (hold_report_o === 1'b1 && n < 80) begin
      tick(1);
      n++;
    end
    chk("hold_len", 8'h01, {7'h0, n >= 45 && n < 80});
    @(posedge core_clk_i);
    fld.line_ok <= 1'b0;
    wait_lock(2500, 8'h01, n);
    chk("hold_lock", 8'h01, {7'h0, n >= 2390});
    fld.line_ok <= 1'b1;
    clear_lock();
    // jumper change past aging: hard lockout refuses reset
    @(posedge core_clk_i);
    jmp <= 3'h3;
    tick(3);
    chk("hard", 8'h01, {7'h0, hard_lockout_o});
    chk("hard_code", 8'h6e, fault_code_o);
    @(posedge core_clk_i);
    lrst <= 1'b1;
    @(posedge core_clk_i);
    lrst <= 1'b0;
    tick(3);
    chk("hard_kept", 8'h01, {7'h0, lockout_o});
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    tick(3);
    chk("hard_cleared", 8'h00, {7'h0, hard_lockout_o});
    complete_run();
  end
  // the scenarios take about 6600 cycles, two of them four-minute waits
  initial begin
    repeat (15000) @(posedge core_clk_i);
    fails++;
    complete_run();
  end
endmodule
`default_nettype wire
